// [clm_pkg.sv]
// Package for the clock-loss watchdog and error monitor: map, fields, timing
package clm_pkg;

  // Register indices as printed; the byte address is four times the index
  localparam logic [7:0] IDX_CLOCK_FAIL_LATCHED    = 8'h28;
  localparam logic [7:0] IDX_CLOCK_FAIL_CURRENT    = 8'h29;
  localparam logic [7:0] IDX_SYSTEM_ERROR_STATUS   = 8'h2a;
  localparam logic [7:0] IDX_CLOCK_WATCHDOG_ENABLE = 8'h2b;
  localparam logic [7:0] IDX_MASTER_CONTROL_REG    = 8'h2c;
  localparam logic [7:0] IDX_CLOCK_MODE_REG        = 8'h2d;
  localparam logic [7:0] IDX_FALLBACK_SELECT_REG   = 8'h2e;
  localparam logic [7:0] IDX_IRQ_STATUS            = 8'h2f;
  localparam logic [7:0] IDX_IRQ_MASK              = 8'h30;

  localparam int unsigned ADDR_W   = 10;
  localparam int unsigned GROUPS   = 8;
  localparam int unsigned CAMS     = 3;

  // Clock group bit positions
  localparam int unsigned BUS_A_GROUP_BIT           = 7;
  localparam int unsigned BUS_B_GROUP_BIT           = 6;
  localparam int unsigned FRAME_COMP_BIT            = 5;
  localparam int unsigned SIXTEEN_MHZ_PAIR_BIT      = 4;
  localparam int unsigned FOUR_TWO_MHZ_BIT          = 3;
  localparam int unsigned SERIAL_CLOCK_BIT          = 2;
  localparam int unsigned DOUBLE_SERIAL_CLOCK_BIT   = 1;
  localparam int unsigned NETWORK_REF_BIT           = 0;

  // System error bit positions
  localparam int unsigned EVEN_CAM_UNDERFLOW_BIT    = 7;
  localparam int unsigned ODD_CAM_UNDERFLOW_BIT     = 6;
  localparam int unsigned LOCAL_CAM_UNDERFLOW_BIT   = 5;
  localparam int unsigned EVEN_CAM_OVERFLOW_BIT     = 4;
  localparam int unsigned ODD_CAM_OVERFLOW_BIT      = 3;
  localparam int unsigned LOCAL_CAM_OVERFLOW_BIT    = 2;
  localparam int unsigned SYSTEM_ERROR_STATUS_RESERVED_BIT       = 1;
  localparam int unsigned FALLBACK_ACTIVE_BIT       = 0;

  // Control fields
  localparam int unsigned MCR_CLEAR_ERRORS_BIT      = 0;
  localparam int unsigned FALLBACK_ENABLE_BIT       = 0;

  // Interrupt status / mask layout
  localparam int unsigned IRQ_CLOCK_FAIL_BIT        = 0;
  localparam int unsigned IRQ_SYSTEM_ERROR_BIT      = 1;
  localparam int unsigned IRQ_FALLBACK_BIT          = 2;
  localparam int unsigned IRQ_W                     = 3;

  localparam logic [7:0]  REG8_RESET                = 8'h00;
  localparam logic [31:0] RDATA_ZERO                = 32'h0000_0000;

  // Timing
  localparam int unsigned CLK_PERIOD_NS             = 50;
  localparam int unsigned WDOG_TIMEOUT_NS           = 250000;
  localparam int unsigned WDOG_TIMEOUT_CYCLES       = WDOG_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned WDOG_CNT_W                = 20;

  typedef struct packed {
    logic [CAMS-1:0] underflow;  // [2] even, [1] odd, [0] local
    logic [CAMS-1:0] overflow;   // [2] even, [1] odd, [0] local
  } clm_cam_evt_t;

endpackage

// [clm_monitor.sv]
// Clock-loss watchdogs, error registers and Avalon-MM slave for the bus interface
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

module clm_monitor
  import clm_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = WDOG_TIMEOUT_CYCLES
)
(
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]   i_avs_address,
  input  wire logic                i_avs_read,
  input  wire logic                i_avs_write,
  input  wire logic [31:0]         i_avs_writedata,
  input  wire logic [3:0]          i_avs_byteenable,
  output logic      [31:0]         o_avs_readdata,
  output logic                     o_avs_waitrequest,
  // Monitored bus clocks, one line per group, asynchronous
  input  wire logic [GROUPS-1:0]   i_mon_clk,
  // CAM error events, one-cycle pulses on i_clk
  input  wire clm_cam_evt_t        i_cam_evt,
  output logic                     o_clock_fault_pin,
  output logic                     o_system_error_pin,
  output logic                     o_fallback_trigger,
  output logic                     o_irq
);

  // Synchronisers and edge detection
  logic [GROUPS-1:0] sync1_reg;
  logic [GROUPS-1:0] sync2_reg;
  logic [GROUPS-1:0] prev_reg;
  logic [GROUPS-1:0] edge_seen;
  logic [GROUPS-1:0] timed_out;

  // Registers
  logic [7:0]        clock_fail_latched_reg;
  logic [7:0]        clock_fail_latched_next;
  logic [7:0]        clock_fail_current_reg;
  logic [7:0]        system_error_status_reg;
  logic [7:0]        system_error_status_next;
  logic [7:0]        clock_watchdog_enable_reg;
  logic [7:0]        clock_mode_reg;
  logic [7:0]        fallback_select_reg;
  logic [IRQ_W-1:0]  irq_status_reg;
  logic [IRQ_W-1:0]  irq_status_next;
  logic [IRQ_W-1:0]  irq_mask_reg;

  // Bus decode
  logic              ack_reg;
  logic              access;
  logic              wr_do;
  logic              rd_do;
  logic              wr_lane0;
  logic              word_ok;
  logic [7:0]        idx;
  logic              clear_errors;
  logic [7:0]        rdata_next;

  logic [7:0]        fail_now;
  logic [7:0]        latched_set;
  logic [7:0]        system_error_status_set;
  logic              fallback_cond;
  logic [IRQ_W-1:0]  irq_events;

  // Two flip-flops before any logic reads the monitored clocks
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end
    else
    begin
      sync1_reg <= i_mon_clk;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign edge_seen = sync2_reg ^ prev_reg;

  // One watchdog per clock group
  genvar g;
  generate
    for (g = 0; g < GROUPS; g++)
    begin : g_wdog
      logic [WDOG_CNT_W-1:0] cnt_reg;
      logic                  expired_reg;

      always_ff @(posedge i_clk)
      begin
        if (!i_rst_n)
        begin
          cnt_reg     <= '0;
          expired_reg <= 1'b0;
        end
        else if (edge_seen[g])
        begin
          cnt_reg     <= '0;
          expired_reg <= 1'b0;
        end
        else if (cnt_reg >= WDOG_CNT_W'(WDOG_CYCLES - 1))
        begin
          expired_reg <= 1'b1;
        end
        else
        begin
          cnt_reg <= cnt_reg + WDOG_CNT_W'(1);
        end
      end

      assign timed_out[g] = expired_reg;
    end
  endgenerate

  // A disabled group's watchdog still runs, so re-enabling it reports at once
  assign fail_now = timed_out & clock_watchdog_enable_reg;

  // Avalon-MM: one wait state, answer at the second edge of a request
  assign access            = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = access & ~ack_reg;
  assign wr_do             = i_avs_write & ack_reg;
  assign rd_do             = i_avs_read & ack_reg;
  assign wr_lane0          = wr_do & i_avs_byteenable[0];
  assign word_ok           = (i_avs_address[1:0] == 2'b00);
  assign idx               = word_ok ? i_avs_address[ADDR_W-1:2] : 8'hff;
  assign clear_errors      = wr_lane0 && (idx == IDX_MASTER_CONTROL_REG)
                             && i_avs_writedata[MCR_CLEAR_ERRORS_BIT];

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= access & ~ack_reg;
  end

  always_comb
  begin
    rdata_next = REG8_RESET;
    case (idx)
      IDX_CLOCK_FAIL_LATCHED:    rdata_next = clock_fail_latched_reg;
      IDX_CLOCK_FAIL_CURRENT:    rdata_next = clock_fail_current_reg;
      IDX_SYSTEM_ERROR_STATUS:   rdata_next = system_error_status_reg;
      IDX_CLOCK_WATCHDOG_ENABLE: rdata_next = clock_watchdog_enable_reg;
      IDX_CLOCK_MODE_REG:        rdata_next = clock_mode_reg;
      IDX_FALLBACK_SELECT_REG:   rdata_next = fallback_select_reg;
      IDX_IRQ_STATUS:            rdata_next = {5'h00, irq_status_reg};
      IDX_IRQ_MASK:              rdata_next = {5'h00, irq_mask_reg};
      default:                   rdata_next = REG8_RESET;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_avs_readdata <= RDATA_ZERO;
    else if (i_avs_read && !ack_reg)
      o_avs_readdata <= {24'h000000, rdata_next};
  end

  // Software-written configuration
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      clock_watchdog_enable_reg <= REG8_RESET;
      clock_mode_reg            <= REG8_RESET;
      fallback_select_reg       <= REG8_RESET;
      irq_mask_reg              <= '0;
    end
    else if (wr_lane0)
    begin
      if (idx == IDX_CLOCK_WATCHDOG_ENABLE)
        clock_watchdog_enable_reg <= i_avs_writedata[7:0];
      if (idx == IDX_CLOCK_MODE_REG)
        clock_mode_reg <= i_avs_writedata[7:0];
      if (idx == IDX_FALLBACK_SELECT_REG)
        fallback_select_reg <= i_avs_writedata[7:0];
      if (idx == IDX_IRQ_MASK)
        irq_mask_reg <= i_avs_writedata[IRQ_W-1:0];
    end
  end

  // Current status follows the watchdog directly
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      clock_fail_current_reg <= REG8_RESET;
    else
      clock_fail_current_reg <= fail_now;
  end

  // Latched failures: set wins over the clear
  assign latched_set = fail_now;

  always_comb
  begin
    clock_fail_latched_next = clock_fail_latched_reg;
    if (clear_errors)
      clock_fail_latched_next = REG8_RESET;
    clock_fail_latched_next = clock_fail_latched_next | latched_set;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      clock_fail_latched_reg <= REG8_RESET;
    else
      clock_fail_latched_reg <= clock_fail_latched_next;
  end

  // Fallback only for enabled groups belonging to the selected clock mode
  // Uses the next latched value, so a clear cannot re-arm fallback from stale bits
  assign fallback_cond = (|(clock_fail_latched_next & clock_watchdog_enable_reg & clock_mode_reg))
                         && fallback_select_reg[FALLBACK_ENABLE_BIT];

  always_comb
  begin
    system_error_status_set = REG8_RESET;
    system_error_status_set[EVEN_CAM_UNDERFLOW_BIT]  = i_cam_evt.underflow[2];
    system_error_status_set[ODD_CAM_UNDERFLOW_BIT]   = i_cam_evt.underflow[1];
    system_error_status_set[LOCAL_CAM_UNDERFLOW_BIT] = i_cam_evt.underflow[0];
    system_error_status_set[EVEN_CAM_OVERFLOW_BIT]   = i_cam_evt.overflow[2];
    system_error_status_set[ODD_CAM_OVERFLOW_BIT]    = i_cam_evt.overflow[1];
    system_error_status_set[LOCAL_CAM_OVERFLOW_BIT]  = i_cam_evt.overflow[0];
    system_error_status_set[FALLBACK_ACTIVE_BIT]     = fallback_cond;
    system_error_status_set[SYSTEM_ERROR_STATUS_RESERVED_BIT]     = 1'b0;
  end

  always_comb
  begin
    system_error_status_next = system_error_status_reg;
    if (clear_errors)
      system_error_status_next = REG8_RESET;
    system_error_status_next = system_error_status_next | system_error_status_set;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      system_error_status_reg <= REG8_RESET;
    else
      system_error_status_reg <= system_error_status_next;
  end

  // Interrupt events: newly set error bits
  assign irq_events[IRQ_CLOCK_FAIL_BIT]   = |(latched_set & ~clock_fail_latched_reg);
  assign irq_events[IRQ_SYSTEM_ERROR_BIT] = |(system_error_status_set & ~system_error_status_reg);
  assign irq_events[IRQ_FALLBACK_BIT]     = fallback_cond & ~system_error_status_reg[FALLBACK_ACTIVE_BIT];

  always_comb
  begin
    irq_status_next = irq_status_reg;
    if (rd_do && (idx == IDX_IRQ_STATUS))
      irq_status_next = '0;
    irq_status_next = irq_status_next | irq_events;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      irq_status_reg <= '0;
    else
      irq_status_reg <= irq_status_next;
  end

  // Output pins come from flip-flops, one cycle behind the registers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_clock_fault_pin  <= 1'b0;
      o_system_error_pin <= 1'b0;
      o_fallback_trigger <= 1'b0;
      o_irq              <= 1'b0;
    end
    else
    begin
      o_clock_fault_pin  <= |clock_fail_latched_reg;
      o_system_error_pin <= (|system_error_status_reg) | (|clock_fail_latched_reg);
      o_fallback_trigger <= system_error_status_reg[FALLBACK_ACTIVE_BIT];
      o_irq              <= |(irq_status_reg & irq_mask_reg);
    end
  end

endmodule

`default_nettype wire

// [clm_monitor_props.sv]
// Port-level assertion checker for the clock-loss monitor
`timescale 1ns/100ps
`default_nettype none
module clm_monitor_props
  import clm_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = 16
)
(
  input wire logic               i_clk,
  input wire logic               i_rst_n,
  input wire logic [ADDR_W-1:0]  i_avs_address,
  input wire logic               i_avs_read,
  input wire logic               i_avs_write,
  input wire logic [31:0]        i_avs_writedata,
  input wire logic [3:0]         i_avs_byteenable,
  input wire logic [31:0]        o_avs_readdata,
  input wire logic               o_avs_waitrequest,
  input wire logic [GROUPS-1:0]  i_mon_clk,
  input wire clm_cam_evt_t       i_cam_evt,
  input wire logic               o_clock_fault_pin,
  input wire logic               o_system_error_pin,
  input wire logic               o_fallback_trigger,
  input wire logic               o_irq
);
  logic [GROUPS-1:0]  prev_reg;
  logic [GROUPS-1:0]  ripe_reg;
  int unsigned        quiet_reg [GROUPS];
  wire logic          clr_acc;
  assign clr_acc = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] && i_avs_writedata[MCR_CLEAR_ERRORS_BIT]
                   && i_avs_address == {IDX_MASTER_CONTROL_REG, 2'b00};
  // Half the timeout leaves slack for the design's two-stage synchroniser
  always_ff @(posedge i_clk)
  begin
    prev_reg <= i_mon_clk;
    for (int g = 0; g < GROUPS; g++)
    begin
      quiet_reg[g] <= (!i_rst_n || i_mon_clk[g] != prev_reg[g]) ? 0 : quiet_reg[g] + 1;
      ripe_reg[g]  <= quiet_reg[g] >= WDOG_CYCLES / 2;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_cam; |i_cam_evt; endsequence
  sequence s_fault_drop; o_clock_fault_pin ##1 !o_clock_fault_pin; endsequence
  sequence s_sys_drop; o_system_error_pin ##1 !o_system_error_pin; endsequence
  property p_one_wait; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus wait not one cycle");
  property p_idle; !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("wait asserted while idle");
  property p_cam_pin; s_cam |-> ##[1:2] o_system_error_pin; endproperty
  a_cam_pin: assert property (p_cam_pin) else $error("cam event missed system error pin");
  property p_fault_keep; s_fault_drop |-> $past(clr_acc) || $past(clr_acc, 2) || $past(clr_acc, 3); endproperty
  a_fault_keep: assert property (p_fault_keep) else $error("clock fault dropped without clear");
  property p_sys_keep; s_sys_drop |-> $past(clr_acc) || $past(clr_acc, 2) || $past(clr_acc, 3); endproperty
  a_sys_keep: assert property (p_sys_keep) else $error("system error dropped without clear");
  property p_fault_in_sys; o_clock_fault_pin |-> o_system_error_pin; endproperty
  a_fault_in_sys: assert property (p_fault_in_sys) else $error("fault not in system error");
  property p_fb_in_sys; o_fallback_trigger |-> o_system_error_pin; endproperty
  a_fb_in_sys: assert property (p_fb_in_sys) else $error("fallback not in system error");
  property p_fb_latched; $rose(o_fallback_trigger) |-> o_clock_fault_pin; endproperty
  a_fb_latched: assert property (p_fb_latched) else $error("fallback without latched fault");
  property p_quiet; $rose(o_clock_fault_pin) |-> |ripe_reg; endproperty
  a_quiet: assert property (p_quiet) else $error("fault raised on toggling clocks");
endmodule
bind clm_monitor clm_monitor_props #(.WDOG_CYCLES(WDOG_CYCLES)) u_props (.i_clk, .i_rst_n, .i_avs_address,
  .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
  .i_mon_clk, .i_cam_evt, .o_clock_fault_pin, .o_system_error_pin, .o_fallback_trigger, .o_irq);
`default_nettype wire

// [clm_clk_src.sv]
// Model of the backplane clock sources feeding the monitor
`timescale 1ns/100ps
`default_nettype none
module clm_clk_src
  import clm_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic [GROUPS-1:0] i_stop,
  input  wire logic [GROUPS-1:0] i_slow,
  output logic      [GROUPS-1:0] o_mon_clk
);
  logic [GROUPS-1:0]  lvl_reg = '0;
  int unsigned        cnt_reg [GROUPS] = '{default: 0};
  assign o_mon_clk = lvl_reg;
  // A dead source holds its last level, as a stopped oscillator would
  always @(posedge i_clk)
  begin
    for (int g = 0; g < GROUPS; g++)
    begin
      cnt_reg[g] <= (cnt_reg[g] >= (i_slow[g] ? 4 : 2)) ? 0 : cnt_reg[g] + 1;
      if (!i_stop[g] && cnt_reg[g] == 0)
        lvl_reg[g] <= !lvl_reg[g];
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the clock-loss monitor
`timescale 1ns/100ps
`default_nettype none
module tb
  import clm_pkg::*;
;
  localparam int unsigned WD    = 16;
  localparam logic [7:0]  LATCH = IDX_CLOCK_FAIL_LATCHED;
  localparam logic [7:0]  CURR  = IDX_CLOCK_FAIL_CURRENT;
  localparam logic [7:0]  SERR  = IDX_SYSTEM_ERROR_STATUS;
  localparam logic [7:0]  CTRL  = IDX_MASTER_CONTROL_REG;
  localparam logic [7:0]  IRQS  = IDX_IRQ_STATUS;
  logic               i_clk            = 1'b0;
  logic               i_rst_n          = 1'b0;
  logic [ADDR_W-1:0]  i_avs_address    = '0;
  logic               i_avs_read       = 1'b0;
  logic               i_avs_write      = 1'b0;
  logic [31:0]        i_avs_writedata  = '0;
  logic [3:0]         i_avs_byteenable = 4'h1;
  logic [GROUPS-1:0]  stop             = '0;
  logic [GROUPS-1:0]  slow             = '0;
  logic [GROUPS-1:0]  mon_clk;
  clm_cam_evt_t       i_cam_evt        = '0;
  logic [31:0]        o_avs_readdata;
  logic               o_avs_waitrequest;
  logic               o_clock_fault_pin;
  logic               o_system_error_pin;
  logic               o_fallback_trigger;
  logic               o_irq;
  logic [31:0]        exp_q[$];
  logic [7:0]         fb;
  logic [5:0]         evt;
  int                 err_total        = 0;
  int                 checks_done      = 0;
  clm_monitor #(.WDOG_CYCLES(WD)) uut (.i_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_mon_clk(mon_clk),
    .i_cam_evt, .o_clock_fault_pin, .o_system_error_pin, .o_fallback_trigger, .o_irq);
  clm_clk_src src (.i_clk, .i_stop(stop), .i_slow(slow), .o_mon_clk(mon_clk));
  initial forever #25 i_clk = ~i_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Request held until waitrequest is sampled low at a rising edge, released at that edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge i_clk);
    i_avs_address   <= {idx, 2'b00};
    i_avs_write     <= wr;
    i_avs_read      <= !wr;
    i_avs_writedata <= {24'h0, d};
    do
      @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0);
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, idx, 8'h00);
  endtask
  task automatic pins(input logic [3:0] e);
    @(negedge i_clk);
    check({28'h0, o_clock_fault_pin, o_system_error_pin, o_fallback_trigger, o_irq}, {28'h0, e});
  endtask
  always @(posedge i_clk)
    if (i_avs_read && o_avs_waitrequest === 1'b0 && exp_q.size() > 0)
      check(o_avs_readdata, exp_q.pop_front());
  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    close_out();
  end
  initial
  begin
    void'($urandom(8583));
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int i = 8'h28; i <= 8'h30; i++)
      rd(8'(i), 8'h00);
    bus(1'b1, 8'h3f, 8'hff);
    bus(1'b1, LATCH, 8'hff);
    rd(8'h3f, 8'h00);
    rd(LATCH, 8'h00);
    stop <= 8'($urandom_range(255, 1));
    slow <= 8'($urandom());
    repeat (40) @(posedge i_clk);
    pins(4'b0000);
    rd(LATCH, 8'h00);
    rd(CURR, 8'h00);
    stop <= 8'h00;
    bus(1'b1, IDX_CLOCK_MODE_REG, 8'h0f);
    bus(1'b1, IDX_FALLBACK_SELECT_REG, 8'h01);
    bus(1'b1, IDX_CLOCK_WATCHDOG_ENABLE, 8'hff);
    rd(IDX_CLOCK_WATCHDOG_ENABLE, 8'hff);
    for (int g = 0; g < GROUPS; g++)
    begin
      fb = (g < 4) ? 8'h01 : 8'h00;
      stop <= 8'h01 << g;
      repeat (40) @(posedge i_clk);
      pins({2'b11, fb[0], 1'b0});
      rd(LATCH, 8'h01 << g);
      rd(CURR, 8'h01 << g);
      stop <= 8'h00;
      repeat (30) @(posedge i_clk);
      rd(CURR, 8'h00);
      rd(LATCH, 8'h01 << g);
      rd(SERR, fb);
      bus(1'b1, CTRL, 8'h01);
      repeat (5) @(posedge i_clk);
      rd(LATCH, 8'h00);
      rd(SERR, 8'h00);
    end
    // Status gathered while masked is dropped unchecked before unmasking
    bus(1'b0, IRQS, 8'h00);
    bus(1'b1, IDX_IRQ_MASK, 8'h07);
    for (int b = 0; b < 7; b++)
    begin
      evt = (b < 6) ? 6'h01 << b : 6'($urandom_range(63, 1));
      i_cam_evt <= clm_cam_evt_t'(evt);
      @(posedge i_clk);
      i_cam_evt <= '0;
      repeat (3) @(posedge i_clk);
      pins(4'b0101);
      bus(1'b1, CTRL, 8'h00);
      rd(SERR, {evt, 2'b00});
      rd(IRQS, 8'h02);
      bus(1'b1, CTRL, 8'h01);
      repeat (3) @(posedge i_clk);
      pins(4'b0000);
      rd(SERR, 8'h00);
    end
    close_out();
  end
endmodule
`default_nettype wire
